/* File: itec_pkg.sv */
package itec_pkg;
    localparam int CHAN_W = 9;
    localparam int SEL_W = 5;
    localparam int SEL_LSB = CHAN_W - SEL_W;
    localparam int CLK_HZ = 125_000_000;
    // Default internal sample period, nanoseconds
    localparam int SAMPLE_PERIOD_NS = 1280;
    localparam int SAMPLE_DIV = (SAMPLE_PERIOD_NS * (CLK_HZ / 1_000_000))
                                / 1000;
    localparam logic [SEL_W-1:0] SEL_RST = 5'h00;
    localparam logic [CHAN_W-1:0] CHAN_RST = 9'h000;

    // Hardware trigger command of the active input procedure
    typedef struct packed {
        logic present;
        logic gated;
    } itec_trig_cmd_s;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h1,
        ST_WAIT = 3'h2,
        ST_RUN = 3'h4
    } itec_state_e;
endpackage : itec_pkg

/* File: itec_ctrl.sv */
`timescale 1ns/1ps
module itec_ctrl #(
    parameter int DIV = itec_pkg::SAMPLE_DIV
) (
    // Clock, reset, enable
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic ce,
    // Sequencer side
    input wire logic proc_start,
    input wire logic proc_stop,
    input wire itec_pkg::itec_trig_cmd_s hw_trigger_command,
    input wire logic ext_clk_sel,
    input wire logic [itec_pkg::CHAN_W-1:0] next_chan,
    output logic sample_take,
    output logic [itec_pkg::CHAN_W-1:0] sample_chan,
    output logic sampling_active,
    // Connector pins
    input wire logic ext_sample_clock_in,
    input wire logic ext_sample_trigger_in,
    output logic sample_clock_out,
    output logic [itec_pkg::SEL_W-1:0] exp_sel
);
    import itec_pkg::*;

    logic [1:0] rst_sync_ff;
    logic rst_n;
    logic [1:0] trig_sync_ff, xclk_sync_ff;
    logic trig_prev_ff, xclk_prev_ff;
    logic [15:0] div_cnt_ff;
    logic int_clk_ff, int_prev_ff;
    itec_state_e state_ff, nxt_state;
    itec_trig_cmd_s cmd_ff;
    logic [CHAN_W-1:0] pend_ff, chan_ff;
    logic [SEL_W-1:0] sel_ff;
    logic take_ff, clkout_ff;

    // Reset release through two flops
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            rst_sync_ff <= 2'h0;
        end else begin
            rst_sync_ff <= {rst_sync_ff[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_ff[1];

    // Pin synchronisers; pull-up makes an open trigger pin read high
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            trig_sync_ff <= 2'h3;
            xclk_sync_ff <= 2'h0;
            trig_prev_ff <= 1'b1;
            xclk_prev_ff <= 1'b0;
        end else if (ce) begin
            trig_sync_ff <= {trig_sync_ff[0], ext_sample_trigger_in};
            xclk_sync_ff <= {xclk_sync_ff[0], ext_sample_clock_in};
            trig_prev_ff <= trig_sync_ff[1];
            xclk_prev_ff <= xclk_sync_ff[1];
        end
    end

    // Edge detection on synchronised pins and the internal divider
    wire trig_w = trig_sync_ff[1];
    wire trig_rise_w = trig_w & ~trig_prev_ff;
    wire xclk_rise_w = xclk_sync_ff[1] & ~xclk_prev_ff;
    wire int_rise_w = int_clk_ff & ~int_prev_ff;
    wire div_end_w = (div_cnt_ff == 16'(DIV / 2 - 1));

    // Internal sample clock: square wave from a divider
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            div_cnt_ff <= 16'h0000;
            int_clk_ff <= 1'b0;
            int_prev_ff <= 1'b0;
        end else if (ce) begin
            div_cnt_ff <= div_end_w ? 16'h0000 : div_cnt_ff + 16'h0001;
            int_clk_ff <= div_end_w ? ~int_clk_ff : int_clk_ff;
            int_prev_ff <= int_clk_ff;
        end
    end

    // Sample tick source selection
    wire tick_w = ext_clk_sel ? xclk_rise_w : int_rise_w;

    // Trigger state decode
    wire start_w = proc_start & ~proc_stop;
    wire run_w = state_ff == ST_RUN;
    wire idle_w = state_ff == ST_IDLE;
    // Gating only applies when a trigger command is present
    wire gate_ok_w = ~(cmd_ff.present & cmd_ff.gated) | trig_w;
    // Restart requests outside idle must not disturb the pending channel
    wire take_w = ce & run_w & tick_w & gate_ok_w;
    wire load_w = ce & ((start_w & idle_w) | take_w);
    wire [CHAN_W-1:0] nxt_pend = next_chan;

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            ST_IDLE: begin
                if (start_w) begin
                    if (!hw_trigger_command.present || trig_w) begin
                        nxt_state = ST_RUN;
                    end else begin
                        nxt_state = ST_WAIT;
                    end
                end
            end
            ST_WAIT: begin
                if (proc_stop) begin
                    nxt_state = ST_IDLE;
                end else if (trig_rise_w) begin
                    nxt_state = ST_RUN;
                end
            end
            ST_RUN: begin
                if (proc_stop) begin
                    nxt_state = ST_IDLE;
                end
            end
            default: begin
                nxt_state = ST_IDLE;
            end
        endcase
    end

    // State and latched trigger mode
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= ST_IDLE;
            cmd_ff <= '0;
        end else if (ce) begin
            state_ff <= nxt_state;
            if (start_w && state_ff == ST_IDLE) begin
                cmd_ff <= hw_trigger_command;
            end
        end
    end

    // Channel pipeline: select shows the channel one tick ahead
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pend_ff <= CHAN_RST;
            chan_ff <= CHAN_RST;
            sel_ff <= SEL_RST;
        end else if (load_w) begin
            pend_ff <= nxt_pend;
            sel_ff <= nxt_pend[CHAN_W-1:SEL_LSB];
            if (take_w) begin
                chan_ff <= pend_ff;
            end
        end
    end

    // Strobe and buffered clock out
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            take_ff <= 1'b0;
            clkout_ff <= 1'b0;
        end else if (ce) begin
            take_ff <= take_w;
            clkout_ff <= int_clk_ff;
        end
    end

    // Bit four leaves on the first select line
    assign exp_sel = sel_ff;
    assign sample_chan = chan_ff;
    assign sample_take = take_ff;
    assign sample_clock_out = clkout_ff;
    assign sampling_active = run_w;

    // Assertions
    a_sel_from_chan: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        load_w |=> exp_sel == $past(next_chan[CHAN_W-1:SEL_LSB]))
        else $error("select not from channel top bits");

    a_sel_held_between: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        !load_w |=> $stable(exp_sel))
        else $error("select changed without a load");

    a_take_matches_sel: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        take_w |=> sample_chan[CHAN_W-1:SEL_LSB] == $past(exp_sel))
        else $error("sample taken with wrong select");

    // Start with a trigger command present and the trigger low must park in the wait state
    sequence s_start_held;
        ce && start_w && idle_w &&
            hw_trigger_command.present && !trig_w;
    endsequence

    a_trig_withholds: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        s_start_held |=> state_ff == ST_WAIT ##1 !sample_take)
        else $error("sampling not withheld");

    a_rise_starts_run: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        ce && state_ff == ST_WAIT && trig_rise_w && !proc_stop
            |=> sampling_active)
        else $error("trigger edge did not start sampling");

    a_no_cmd_runs: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        ce && start_w && idle_w && !hw_trigger_command.present
            |=> sampling_active)
        else $error("trigger not ignored without command");

    a_no_cmd_ungated: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        ce && run_w && tick_w && !cmd_ff.present |=> sample_take)
        else $error("plain procedure missed a tick");

    a_gated_stops: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        ce && run_w && cmd_ff.present && cmd_ff.gated && !trig_w
            |=> !sample_take)
        else $error("gated mode sampled with trigger low");

    a_clock_copy: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        ce |=> sample_clock_out == $past(int_clk_ff))
        else $error("clock output not a copy");

    a_ext_clock_tick: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        ce && run_w && ext_clk_sel && !xclk_rise_w |=> !sample_take)
        else $error("sample without external clock edge");
endmodule : itec_ctrl

/* File: itec_far_model.sv */
`timescale 1ns/1ps
module itec_far_model (
    // Test controls
    input wire logic trig_drive,
    input wire logic trig_lvl,
    input wire logic clk_run,
    // Connector pins
    input wire logic [itec_pkg::SEL_W-1:0] exp_sel,
    output logic ext_sample_clock_in,
    output logic ext_sample_trigger_in,
    output logic [2:0] board_sel
);
    import itec_pkg::*;
    // Released trigger floats to the pull-up level
    assign ext_sample_trigger_in = trig_drive ? trig_lvl : 1'b1;
    // Board is picked by the top three channel bits
    assign board_sel = exp_sel[4:2];
    // Source clock stands still unless asked to run
    // Odd offset keeps pin edges away from the system clock edges
    initial begin
        ext_sample_clock_in = 1'b0;
        #1;
        forever #20 ext_sample_clock_in = clk_run & ~ext_sample_clock_in;
    end
endmodule : itec_far_model

/* File: test_input_trigger_expansion_ctrl.sv */
`timescale 1ns/1ps
module test_input_trigger_expansion_ctrl;
    import itec_pkg::*;
    logic clk_sys = 0, rstn = 0, proc_start = 0, proc_stop = 0;
    logic ext_clk_sel = 0, trig_drive = 1, trig_lvl = 0, clk_run = 0;
    logic sample_take, sampling_active, sample_clock_out;
    logic ext_sample_clock_in, ext_sample_trigger_in;
    logic [CHAN_W-1:0] next_chan = 9'h000, sample_chan;
    logic [SEL_W-1:0] exp_sel;
    logic [2:0] board_sel;
    logic last_clk;
    itec_trig_cmd_s hw_trigger_command = '0;
    int err_count = 0, comparisons = 0, k;
    // Small divider keeps every wait short
    itec_ctrl #(.DIV(4)) itec_ctrl_i (.clk_sys(clk_sys), .rstn(rstn),
        .ce(1'b1), .proc_start(proc_start), .proc_stop(proc_stop),
        .hw_trigger_command(hw_trigger_command), .ext_clk_sel(ext_clk_sel),
        .next_chan(next_chan), .sample_take(sample_take),
        .sample_chan(sample_chan), .sampling_active(sampling_active),
        .ext_sample_clock_in(ext_sample_clock_in),
        .ext_sample_trigger_in(ext_sample_trigger_in),
        .sample_clock_out(sample_clock_out), .exp_sel(exp_sel));
    itec_far_model itec_far_model_i (.trig_drive(trig_drive),
        .trig_lvl(trig_lvl), .clk_run(clk_run), .exp_sel(exp_sel),
        .ext_sample_clock_in(ext_sample_clock_in),
        .ext_sample_trigger_in(ext_sample_trigger_in),
        .board_sel(board_sel));
    always #4 clk_sys = ~clk_sys;
    task automatic chk(input string nm, input logic [8:0] seen, exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("FAIL %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    // Counts takes over n cycles; the pulse stands one cycle
    task automatic takes(input int n);
        k = 0;
        repeat (n) begin
            @(negedge clk_sys);
            if (sample_take === 1'b1) k++;
        end
    endtask : takes
    // Select must stay on the pending channel until its take
    task automatic wait_take(input logic [8:0] pend);
        for (int i = 0; i < 20 && sample_take !== 1'b1; i++) begin
            chk("exp_sel held", 9'(exp_sel), 9'(pend[8:4]));
            @(negedge clk_sys);
        end
        chk("take", 9'(sample_take), 9'h001);
    endtask : wait_take
    task automatic start(input logic p, g);
        @(negedge clk_sys);
        hw_trigger_command = '{p, g};
        proc_start = 1;
        @(negedge clk_sys);
        proc_start = 0;
    endtask : start
    task automatic stop;
        @(negedge clk_sys);
        proc_stop = 1;
        @(negedge clk_sys);
        proc_stop = 0;
        repeat (2) @(negedge clk_sys);
    endtask : stop
    // No command: low trigger is ignored, top bits reach the pins
    task automatic t_plain;
        next_chan = 9'h1f0;
        start(0, 1);
        next_chan = 9'h0ab;
        chk("active", 9'(sampling_active), 9'h001);
        wait_take(9'h1f0);
        chk("sample_chan", sample_chan, 9'h1f0);
        chk("exp_sel", 9'(exp_sel), 9'h00a);
        chk("board", 9'(board_sel), 9'h002);
        // Divider of four toggles the copy every second cycle
        k = 0;
        repeat (64) begin
            last_clk = sample_clock_out;
            @(negedge clk_sys);
            if (sample_clock_out !== last_clk) k++;
        end
        chk("clk out toggles", 9'(k), 9'h020);
        stop();
        chk("idle after stop", 9'(sampling_active), 9'h000);
        $display("t_plain done");
    endtask : t_plain
    // One-shot: waits for the rise, then ignores the level
    task automatic t_oneshot;
        start(1, 0);
        takes(16);
        chk("withheld", 9'(k), 9'h000);
        chk("withheld active", 9'(sampling_active), 9'h000);
        trig_lvl = 1;
        wait_take(9'h0ab);
        trig_lvl = 0;
        takes(16);
        chk("keeps running", 9'(k != 0), 9'h001);
        stop();
        $display("t_oneshot done");
    endtask : t_oneshot
    task automatic t_gated;
        start(1, 1);
        takes(16);
        chk("gated high", 9'(k != 0), 9'h001);
        trig_lvl = 0;
        repeat (4) @(negedge clk_sys);
        takes(16);
        chk("gated low", 9'(k), 9'h000);
        stop();
        $display("t_gated done");
    endtask : t_gated
    // Open trigger reads active; only the pin clock ticks
    task automatic t_ext;
        trig_drive = 0;
        ext_clk_sel = 1;
        start(1, 1);
        takes(16);
        chk("no ext clock", 9'(k), 9'h000);
        clk_run = 1;
        wait_take(9'h0ab);
        clk_run = 0;
        stop();
        $display("t_ext done");
    endtask : t_ext
    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : stop_test
    initial begin
        repeat (12) @(negedge clk_sys);
        rstn = 1;
        repeat (6) @(negedge clk_sys);
        t_plain();
        trig_lvl = 1;
        t_gated();
        t_oneshot();
        t_ext();
        stop_test();
    end
    // Watchdog well beyond the few hundred cycles the tests need
    initial begin
        #80000;
        err_count++;
        stop_test();
    end
endmodule : test_input_trigger_expansion_ctrl
